/* File: core/gpio_cal_pkg.sv */
/*
  constants for the pin port control and calibration register block:
  register addresses, field positions, reset values, serial framing.
  assumes nothing beyond a systemverilog compiler.
*/
package gpio_cal_pkg;

  localparam int          REG_ADDR_W        = 7;
  localparam logic [6:0]  ADDR_PIN_PORT     = 7'h04;
  localparam logic [6:0]  ADDR_OFFSET_LOW   = 7'h05;
  localparam logic [6:0]  ADDR_OFFSET_MID   = 7'h06;
  localparam logic [6:0]  ADDR_OFFSET_HIGH  = 7'h07;
  localparam logic [6:0]  ADDR_GAIN_LOW     = 7'h08;
  localparam logic [6:0]  ADDR_GAIN_MID     = 7'h09;
  localparam logic [6:0]  ADDR_GAIN_HIGH    = 7'h0a;

  // pin port control field positions
  localparam int          PIN_B_DIR_BIT     = 5;
  localparam int          PIN_A_DIR_BIT     = 4;
  localparam int          PIN_B_LEVEL_BIT   = 1;
  localparam int          PIN_A_LEVEL_BIT   = 0;

  localparam logic [7:0]  PIN_PORT_RESET    = 8'he0;
  localparam logic [23:0] CAL_WORD_RESET    = 24'h000000;
  localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

  // command byte: top bit selects read, low bits the address
  localparam int          CMD_READ_BIT      = 7;

  localparam int          SYNC_STAGES       = 3;
  localparam int          BIT_CNT_W         = 3;
  localparam int          CLK_DIV_W         = 3;

  typedef enum logic [1:0] {
    RATE_OFF     = 2'b00,
    RATE_FULL    = 2'b01,
    RATE_HALF    = 2'b10,
    RATE_QUARTER = 2'b11
  } clock_output_function_rate_t;

  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b00,
    FRAME_CMD  = 2'b01,
    FRAME_DATA = 2'b10
  } frame_state_t;

endpackage

/* File: core/serial_byte_port.sv */
/*
  serial slave for the register port: clock polarity 0, phase 1.
  samples the serial pins on core_clk; serial clock must stay well
  below core_clk/8 so every edge is seen after synchronisation.
*/
module serial_byte_port
  import gpio_cal_pkg::*;
(
  input  wire logic       core_clk,   // system clock
  input  wire logic       rst_b,      // sync reset, active low
  input  wire logic       sclk,       // serial clock pin
  input  wire logic       cs_b,       // chip select pin, active low
  input  wire logic       din,        // serial data in pin
  input  wire logic [7:0] tx_byte,    // byte to shift out next
  output logic            dout,       // serial data out pin
  output logic            dout_oe,    // drive enable for dout
  output logic            frame_on,   // chip select seen active
  output logic            byte_valid, // one-cycle byte received
  output logic [7:0]      byte_data   // received byte
);

  logic [SYNC_STAGES-1:0] sclk_sync;
  logic [SYNC_STAGES-1:0] cs_sync;
  logic [SYNC_STAGES-1:0] din_sync;
  logic                   sclk_f;
  logic                   cs_f;
  logic                   din_f;
  logic [BIT_CNT_W-1:0]   rx_cnt;
  logic [BIT_CNT_W-1:0]   tx_cnt;
  logic [7:0]             rx_shift;
  logic [7:0]             tx_shift;
  logic                   sclk_rise;
  logic                   sclk_fall;

  // three stages; a change counts when the last two agree
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sclk_sync <= '0;
      cs_sync   <= '1;
      din_sync  <= '0;
      sclk_f    <= 1'b0;
      cs_f      <= 1'b1;
      din_f     <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      cs_sync   <= {cs_sync[1:0], cs_b};
      din_sync  <= {din_sync[1:0], din};
      if (sclk_sync[1] == sclk_sync[2]) sclk_f <= sclk_sync[2];
      if (cs_sync[1] == cs_sync[2])     cs_f   <= cs_sync[2];
      if (din_sync[1] == din_sync[2])   din_f  <= din_sync[2];
    end
  end

  assign sclk_rise = !cs_f && (sclk_sync[1] == sclk_sync[2]) &&
                     sclk_sync[2] && !sclk_f;
  assign sclk_fall = !cs_f && (sclk_sync[1] == sclk_sync[2]) &&
                     !sclk_sync[2] && sclk_f;

  // data in is taken on the falling serial edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_cnt     <= '0;
      rx_shift   <= 8'h00;
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (cs_f) begin
        rx_cnt <= '0;
      end else if (sclk_fall) begin
        rx_shift <= {rx_shift[6:0], din_f};
        rx_cnt   <= rx_cnt + 1'b1;
        if (rx_cnt == 3'd7) begin
          byte_valid <= 1'b1;
          byte_data  <= {rx_shift[6:0], din_f};
        end
      end
    end
  end

  // data out changes only on the rising serial edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_cnt   <= '0;
      tx_shift <= 8'h00;
      dout     <= 1'b0;
      dout_oe  <= 1'b0;
      frame_on <= 1'b0;
    end else begin
      frame_on <= !cs_f;
      dout_oe  <= !cs_f;
      if (cs_f) begin
        tx_cnt <= '0;
      end else if (sclk_rise) begin
        tx_cnt <= tx_cnt + 1'b1;
        if (tx_cnt == '0) begin
          tx_shift <= {tx_byte[6:0], 1'b0};
          dout     <= tx_byte[7];
        end else begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          dout     <= tx_shift[7];
        end
      end
    end
  end

endmodule // serial_byte_port

/* File: core/adc_gpio_and_cal_registers.sv */
/*
  pin port control and calibration registers of the converter, with
  the two general-purpose pins and the clock output on pin a.
  assumes an external serial master, two-way pins resolved outside,
  and a clock output rate field held elsewhere and reset only by
  the hardware reset pin.
*/

// Functional notes
// - pin port control at 04h, resets E0h
// - bit 5 clear makes pin b output
// - bit 4 clear makes pin a output
// - bit 1 reads pin b's actual level
// - pin b output: bit 1 write drives pin
// - pin b input: bit 1 write ignored
// - pin a input: reads pin, ignores writes
// - pin a level write only when clock off
// - offset word at 05h-07h, low byte first
// - gain word at 08h-0Ah, low byte first
// - serial clock idles low, change rise, sample fall
// - rate field selects clock output on pin a
module adc_gpio_and_cal_registers
  import gpio_cal_pkg::*;
(
  input  wire logic        core_clk,          // 40 MHz system clock
  input  wire logic        rst_b,             // sync reset, active low
  input  wire logic        sclk,              // serial clock pin
  input  wire logic        cs_b,              // chip select, active low
  input  wire logic        din,               // serial data in
  output logic             dout,              // serial data out
  output logic             dout_oe,           // dout drive enable
  input  wire logic [1:0]  clock_output_rate, // pin a clock select
  input  wire logic        gpio_pin_a_in,     // pin a level seen
  output logic             gpio_pin_a_out,    // pin a drive value
  output logic             gpio_pin_a_oe,     // pin a drive enable
  input  wire logic        gpio_pin_b_in,     // pin b level seen
  output logic             gpio_pin_b_out,    // pin b drive value
  output logic             gpio_pin_b_oe,     // pin b drive enable
  output logic [23:0]      offset_correction_word, // offset word
  output logic [23:0]      gain_correction_word    // gain word
);

  logic                   frame_on;
  logic                   byte_valid;
  logic [7:0]             byte_data;
  logic [7:0]             rd_data;
  frame_state_t           frame_state;
  logic [REG_ADDR_W-1:0]  cur_addr;
  logic                   cur_read;
  logic                   wr_strobe;
  logic [7:0]             pin_port_control;
  logic [SYNC_STAGES-1:0] pin_a_sync;
  logic [SYNC_STAGES-1:0] pin_b_sync;
  logic                   pin_a_level_seen;
  logic                   pin_b_level_seen;
  logic [CLK_DIV_W-1:0]   div_cnt;
  logic                   pin_a_is_output;
  logic                   pin_b_is_output;
  logic                   clock_out_on;
  clock_output_function_rate_t           rate;

  serial_byte_port u_port (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .sclk       (sclk),
    .cs_b       (cs_b),
    .din        (din),
    .tx_byte    (rd_data),
    .dout       (dout),
    .dout_oe    (dout_oe),
    .frame_on   (frame_on),
    .byte_valid (byte_valid),
    .byte_data  (byte_data)
  );

  assign rate            = clock_output_function_rate_t'(clock_output_rate);
  assign pin_a_is_output = !pin_port_control[PIN_A_DIR_BIT];
  assign pin_b_is_output = !pin_port_control[PIN_B_DIR_BIT];
  assign clock_out_on    = (rate != RATE_OFF);
  assign wr_strobe       = byte_valid && frame_state == FRAME_DATA &&
                           !cur_read;

  // first byte of a frame is the command, later bytes are data
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      frame_state <= FRAME_IDLE;
      cur_addr    <= '0;
      cur_read    <= 1'b0;
    end else begin
      case (frame_state)
        FRAME_IDLE: begin
          if (frame_on) frame_state <= FRAME_CMD;
        end
        FRAME_CMD: begin
          if (!frame_on) begin
            frame_state <= FRAME_IDLE;
          end else if (byte_valid) begin
            cur_addr    <= byte_data[REG_ADDR_W-1:0];
            cur_read    <= byte_data[CMD_READ_BIT];
            frame_state <= FRAME_DATA;
          end
        end
        FRAME_DATA: begin
          if (!frame_on) begin
            frame_state <= FRAME_IDLE;
          end else if (byte_valid) begin
            cur_addr <= cur_addr + 1'b1;
          end
        end
        default: frame_state <= FRAME_IDLE;
      endcase
    end
  end

  // pin levels pass three stages before use
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_a_sync       <= '0;
      pin_b_sync       <= '0;
      pin_a_level_seen <= 1'b0;
      pin_b_level_seen <= 1'b0;
    end else begin
      pin_a_sync <= {pin_a_sync[1:0], gpio_pin_a_in};
      pin_b_sync <= {pin_b_sync[1:0], gpio_pin_b_in};
      if (pin_a_sync[1] == pin_a_sync[2])
        pin_a_level_seen <= pin_a_sync[2];
      if (pin_b_sync[1] == pin_b_sync[2])
        pin_b_level_seen <= pin_b_sync[2];
    end
  end

  // pin port control register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_port_control <= PIN_PORT_RESET;
    end else if (wr_strobe && cur_addr == ADDR_PIN_PORT) begin
      pin_port_control[7:2] <= byte_data[7:2];
      if (pin_b_is_output)
        pin_port_control[PIN_B_LEVEL_BIT] <=
          byte_data[PIN_B_LEVEL_BIT];
      if (pin_a_is_output && !clock_out_on)
        pin_port_control[PIN_A_LEVEL_BIT] <=
          byte_data[PIN_A_LEVEL_BIT];
    end
  end

  // calibration words, low byte at the lowest address
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      offset_correction_word <= CAL_WORD_RESET;
      gain_correction_word   <= CAL_WORD_RESET;
    end else if (wr_strobe) begin
      case (cur_addr)
        ADDR_OFFSET_LOW:  offset_correction_word[7:0]   <= byte_data;
        ADDR_OFFSET_MID:  offset_correction_word[15:8]  <= byte_data;
        ADDR_OFFSET_HIGH: offset_correction_word[23:16] <= byte_data;
        ADDR_GAIN_LOW:    gain_correction_word[7:0]     <= byte_data;
        ADDR_GAIN_MID:    gain_correction_word[15:8]    <= byte_data;
        ADDR_GAIN_HIGH:   gain_correction_word[23:16]   <= byte_data;
        default: ;
      endcase
    end
  end

  // read data follows the current address; loaded at the next byte
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_data <= UNMAPPED_READ;
    end else begin
      case (cur_addr)
        ADDR_PIN_PORT: begin
          rd_data <= pin_port_control;
          rd_data[PIN_B_LEVEL_BIT] <= pin_b_level_seen;
          if (!pin_a_is_output)
            rd_data[PIN_A_LEVEL_BIT] <= pin_a_level_seen;
        end
        ADDR_OFFSET_LOW:  rd_data <= offset_correction_word[7:0];
        ADDR_OFFSET_MID:  rd_data <= offset_correction_word[15:8];
        ADDR_OFFSET_HIGH: rd_data <= offset_correction_word[23:16];
        ADDR_GAIN_LOW:    rd_data <= gain_correction_word[7:0];
        ADDR_GAIN_MID:    rd_data <= gain_correction_word[15:8];
        ADDR_GAIN_HIGH:   rd_data <= gain_correction_word[23:16];
        default:          rd_data <= UNMAPPED_READ;
      endcase
    end
  end

  // free-running divider for the clock output
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // pin a: clock output when selected, else the level bit
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gpio_pin_a_out <= 1'b0;
      gpio_pin_a_oe  <= 1'b0;
    end else begin
      gpio_pin_a_oe <= pin_a_is_output;
      case (rate)
        RATE_FULL:      gpio_pin_a_out <= div_cnt[0];
        RATE_HALF:      gpio_pin_a_out <= div_cnt[1];
        RATE_QUARTER:   gpio_pin_a_out <= div_cnt[2];
        default:
          gpio_pin_a_out <= pin_port_control[PIN_A_LEVEL_BIT];
      endcase
    end
  end

  // pin b follows its level bit while it is an output
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gpio_pin_b_out <= 1'b0;
      gpio_pin_b_oe  <= 1'b0;
    end else begin
      gpio_pin_b_oe  <= pin_b_is_output;
      gpio_pin_b_out <= pin_port_control[PIN_B_LEVEL_BIT];
    end
  end

endmodule // adc_gpio_and_cal_registers

/* File: bench/gpio_cal_sva.sv */
/* port assertions for the pin port and calibration register block.
   assumes binding to its top module; sees only that module's ports. */
module gpio_cal_sva (
  input wire logic        core_clk,               // clock
  input wire logic        rst_b,                  // reset
  input wire logic        sclk,                   // serial clock
  input wire logic        cs_b,                   // select
  input wire logic        din,                    // serial in
  input wire logic        dout,                   // serial out
  input wire logic        dout_oe,                // out enable
  input wire logic [1:0]  clock_output_rate,      // rate field
  input wire logic        gpio_pin_a_in,          // pin a seen
  input wire logic        gpio_pin_a_out,         // pin a drive
  input wire logic        gpio_pin_a_oe,          // pin a enable
  input wire logic        gpio_pin_b_in,          // pin b seen
  input wire logic        gpio_pin_b_out,         // pin b drive
  input wire logic        gpio_pin_b_oe,          // pin b enable
  input wire logic [23:0] offset_correction_word, // offset
  input wire logic [23:0] gain_correction_word    // gain
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_reset_dirs: assert property ($rose(rst_b) |=>
    gpio_pin_a_oe && !gpio_pin_b_oe) else $error("pin direction at reset");
  chk_pin_b_hold: assert property (cs_b [*3] |->
    $stable(gpio_pin_b_out)) else $error("pin b moved outside a write");
  chk_pin_a_hold: assert property (
    (cs_b && clock_output_rate == 2'b00) [*3] |-> $stable(gpio_pin_a_out))
    else $error("pin a moved outside a write");
  chk_clk_full: assert property (
    (clock_output_rate == 2'b01 && gpio_pin_a_oe) [*3]
    |-> gpio_pin_a_out != $past(gpio_pin_a_out)) else $error("rate 01");
  chk_clk_half: assert property (
    (clock_output_rate == 2'b10 && gpio_pin_a_oe) [*4]
    |-> gpio_pin_a_out != $past(gpio_pin_a_out, 2)) else $error("rate 10");
  chk_clk_quarter: assert property (
    (clock_output_rate == 2'b11 && gpio_pin_a_oe) [*6]
    |-> gpio_pin_a_out != $past(gpio_pin_a_out, 4)) else $error("rate 11");
  chk_oe_off: assert property (cs_b [*6] |-> !dout_oe)
    else $error("dout driven while deselected");
  chk_oe_on: assert property ((!cs_b) [*6] |-> dout_oe)
    else $error("dout released while selected");
  chk_dout_edge: assert property (
    !cs_b && $past(cs_b, 8) == 1'b0 && $changed(dout) |-> sclk)
    else $error("dout changed while serial clock low");
  chk_word_hold: assert property (cs_b [*3] |->
    $stable(offset_correction_word) && $stable(gain_correction_word))
    else $error("calibration word moved outside a write");

  cov_clk_out: cover property (clock_output_rate != 2'b00 && gpio_pin_a_oe);
  cov_pin_b_out: cover property (gpio_pin_b_oe && gpio_pin_b_out);
  cov_read: cover property (dout_oe && dout);
  cov_in_a: cover property (!gpio_pin_a_oe && gpio_pin_a_in);
  cov_in_b: cover property (!gpio_pin_b_oe && gpio_pin_b_in);
endmodule // gpio_cal_sva

bind adc_gpio_and_cal_registers gpio_cal_sva i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
  .din(din), .dout(dout), .dout_oe(dout_oe),
  .clock_output_rate(clock_output_rate),
  .gpio_pin_a_in(gpio_pin_a_in), .gpio_pin_a_out(gpio_pin_a_out),
  .gpio_pin_a_oe(gpio_pin_a_oe), .gpio_pin_b_in(gpio_pin_b_in),
  .gpio_pin_b_out(gpio_pin_b_out), .gpio_pin_b_oe(gpio_pin_b_oe),
  .offset_correction_word(offset_correction_word),
  .gain_correction_word(gain_correction_word)
);

/* File: bench/serial_master_model.sv */
/* serial master in place of the controller: clock polarity 0, phase 1.
   assumes a core clock to pace edges; half period set by half_cyc. */
module serial_master_model (
  input wire logic core_clk, // pacing clock
  input wire logic dout,     // serial data from device
  output logic     sclk,     // serial clock
  output logic     cs_b,     // select, active low
  output logic     din       // serial data to device
);
  timeunit 1ns;
  timeprecision 100ps;
  int half_cyc = 10;

  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    din  = 1'b0;
  end

  task automatic hp;
    repeat (half_cyc) @(posedge core_clk);
    #1;
  endtask

  // command byte, then n data bytes low byte first; reads stream n bytes the same way
  task automatic frame(input logic [7:0] cmd, input int n,
                       input logic [23:0] wr, output logic [23:0] rd);
    logic [31:0] tx;
    tx = {wr, cmd};
    rd = 24'h000000;
    cs_b = 1'b0;
    hp();
    for (int b = 0; b <= n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        sclk = 1'b1;
        din  = tx[8*b+i];
        hp();
        sclk = 1'b0;
        if (b > 0) rd[8*(b-1)+i] = dout;
        hp();
      end
    end
    cs_b = 1'b1;
    din  = ~din;
    hp();
  endtask
endmodule // serial_master_model

/* File: bench/adc_gpio_and_cal_registers_tb.sv */
/* self-checking bench for the pin port and calibration registers.
   assumes the serial master model drives the register port. */
module adc_gpio_and_cal_registers_tb
  import gpio_cal_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

  logic        core_clk = 1'b0, rst_b = 1'b0, ext_a = 1'b0, ext_b = 1'b0;
  logic [1:0]  rate     = 2'b00;
  logic        sclk, cs_b, din, dout, dout_oe, a_out, a_oe, b_out, b_oe;
  logic [23:0] ofs, gain, rd;
  int          mismatches = 0;
  int          n_checks   = 0;
  wire         a_in = a_oe ? a_out : ext_a;
  wire         b_in = b_oe ? b_out : ext_b;
  // undriven serial out shows the inverse of the last bit
  wire         dout_bus = dout_oe ? dout : ~dout;

  always #12.5 core_clk = ~core_clk;

  serial_master_model i_mst (.core_clk(core_clk), .dout(dout_bus),
    .sclk(sclk), .cs_b(cs_b), .din(din));

  adc_gpio_and_cal_registers i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout), .dout_oe(dout_oe),
    .clock_output_rate(rate), .gpio_pin_a_in(a_in),
    .gpio_pin_a_out(a_out), .gpio_pin_a_oe(a_oe), .gpio_pin_b_in(b_in),
    .gpio_pin_b_out(b_out), .gpio_pin_b_oe(b_oe),
    .offset_correction_word(ofs), .gain_correction_word(gain));

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input int n, input logic [23:0] v);
    i_mst.frame({1'b0, a}, n, v, rd);
  endtask

  task automatic rdv(input logic [6:0] a, input int n,
                     output logic [23:0] v);
    i_mst.frame({1'b1, a}, n, 24'h000000, v);
  endtask

  task automatic results;
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin : main
    logic [23:0] v, val;
    logic        s;
    int          h;
    cyc(10);
    rst_b = 1'b1;
    cyc(2);
    `CHK({a_oe, b_oe}, 2'b10)
    rdv(ADDR_PIN_PORT, 1, v);
    `CHK(v[7:0], PIN_PORT_RESET)
    wr(ADDR_PIN_PORT, 1, 24'hc0);
    wr(ADDR_PIN_PORT, 1, 24'hc2);
    `CHK({b_oe, b_out}, 2'b11)
    rdv(ADDR_PIN_PORT, 1, v);
    `CHK(v[7:0], 8'hc2)
    wr(ADDR_PIN_PORT, 1, 24'he0);
    ext_b = 1'b1;
    wr(ADDR_PIN_PORT, 1, 24'he2);
    rdv(ADDR_PIN_PORT, 1, v);
    `CHK(v[7:0], 8'he2)
    ext_b = 1'b0;
    wr(ADDR_PIN_PORT, 1, 24'hc2);
    `CHK({b_oe, b_out}, 2'b10)
    wr(ADDR_PIN_PORT, 1, 24'hf0);
    ext_a = 1'b1;
    wr(ADDR_PIN_PORT, 1, 24'hf1);
    rdv(ADDR_PIN_PORT, 1, v);
    `CHK(v[7:0], 8'hf1)
    ext_a = 1'b0;
    rdv(ADDR_PIN_PORT, 1, v);
    `CHK(v[7:0], 8'hf0)
    wr(ADDR_PIN_PORT, 1, 24'he1);
    `CHK({a_oe, a_out}, 2'b10)
    wr(ADDR_PIN_PORT, 1, 24'he1);
    `CHK(a_out, 1'b1)
    rate = RATE_HALF;
    wr(ADDR_PIN_PORT, 1, 24'he0);
    rate = RATE_OFF;
    cyc(3);
    `CHK(a_out, 1'b1)
    for (int r = 1; r < 4; r++) begin
      rate = r[1:0];
      h    = 1 << (r - 1);
      cyc(12);
      s = a_out;
      for (int k = 1; k < 5; k++) begin
        cyc(h);
        `CHK(a_out, s ^ k[0])
      end
    end
    rate = RATE_OFF;
    i_mst.half_cyc = 16;
    for (int i = 0; i < 2; i++) begin
      val = i ? 24'ha5c37e : 24'h5a3c81;
      wr(i ? ADDR_GAIN_LOW : ADDR_OFFSET_LOW, 3, val);
      `CHK(i ? gain : ofs, val)
      rdv(i ? ADDR_GAIN_LOW : ADDR_OFFSET_LOW, 3, v);
      `CHK(v, val)
      rdv(i ? ADDR_GAIN_HIGH : ADDR_OFFSET_HIGH, 1, v);
      `CHK(v[7:0], val[23:16])
    end
    wr(7'h0b, 1, 24'hff);
    rdv(7'h0b, 1, v);
    `CHK(v[7:0], UNMAPPED_READ)
    `CHK(ofs, 24'h5a3c81)
    rst_b = 1'b0;
    cyc(10);
    rst_b = 1'b1;
    cyc(2);
    `CHK({ofs, gain}, {2{CAL_WORD_RESET}})
    `CHK({a_oe, a_out, b_oe}, 3'b100)
    rdv(ADDR_PIN_PORT, 1, v);
    `CHK(v[7:0], PIN_PORT_RESET)
    results();
  end

  initial begin : watchdog
    #(40000 * 25);
    mismatches++;
    results();
  end
endmodule // adc_gpio_and_cal_registers_tb
